// ===== ats_sequencer.sv
// Purpose: start/reference trigger selection, scan and conversion pacing,
//          sample counter sequencing and input-mode multiplexer control
// Assumes: trigger lines are asynchronous; one clock; 16 mux inputs
// Notes:   register port reads back one cycle after the read strobe
`include "ats_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module ats_sequencer
	import ats_pkg::*;
#(
	parameter int CW = 16
) (
	// Clock and reset
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	// Register port
	input  wire logic [7:0]                reg_addr,
	input  wire logic [31:0]               reg_wdata,
	input  wire logic                      reg_wr,
	input  wire logic                      reg_rd,
	output var  logic [31:0]               reg_rdata,
	// Trigger sources
	input  wire logic [`ATS_NUM_PFI-1:0]   programmable_function_line,
	input  wire logic [`ATS_NUM_BTL-1:0]   backplane_trigger_line,
	input  wire logic [`ATS_NUM_INT-1:0]   internal_trigger,
	input  wire logic                      analog_compare_event,
	input  wire logic                      ext_scan_clock,
	// Start trigger pin, enable low while driving
	output var  logic                      start_trigger_pin_o,
	output var  logic                      start_trigger_pin_oe_n,
	// Timing outputs
	output var  logic                      scan_clock,
	output var  logic                      conversion_clock,
	output var  logic                      acq_running,
	// Input multiplexer
	output var  ats_mux_t                  mux_ctl
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [31:0] ctrl;
		logic [CW-1:0] pre_cnt;
		logic [CW-1:0] post_cnt;
		logic [15:0] scan_div;
		logic [15:0] conv_div;
		logic [15:0] delay;
		logic [3:0] nchan;
		logic [31:0] modes;
		ats_state_t st;
		logic [CW-1:0] count;
		logic [15:0] tick;
		logic [15:0] ctick;
		logic [3:0] chan;
		logic conv_busy;
		logic conv_lead;
		logic done;
		logic run;
		logic [`ATS_NUM_PFI+`ATS_NUM_BTL+`ATS_NUM_INT+3:0] s1;
		logic [`ATS_NUM_PFI+`ATS_NUM_BTL+`ATS_NUM_INT+3:0] s2;
		logic strg_d;
		logic rtrg_d;
		logic ana_d;
		logic escan_d;
		logic pin_o;
		logic pin_oe_n;
		logic scan;
		logic conv;
		logic [31:0] rdata;
		ats_mux_t mux;
	} ats_reg_t;

	ats_reg_t r_r, r_nxt;

	localparam int SW = `ATS_NUM_PFI + `ATS_NUM_BTL + `ATS_NUM_INT;

	function automatic logic pick(input logic [SW-1:0] v, input logic [4:0] s);
		pick = (s < 5'(SW)) ? v[s] : 1'b0;
	endfunction : pick

	function automatic ats_inmode_t mode_of(input logic [31:0] m,
		input logic [3:0] c);
		mode_of = ats_inmode_t'(m[{c, 1'b0} +: 2]);
	endfunction : mode_of

	logic [SW-1:0] lines;
	logic start_lvl, ref_lvl;
	logic start_edge, ref_edge, ana_rise, escan_rise;
	logic scan_pulse, go;
	ats_inmode_t cm, pm;
	logic [3:0] pchan;

	always_comb begin
		r_nxt = r_r;
		// Only the second synchroniser stage feeds logic
		lines = r_r.s2[SW-1:0];
		start_lvl = pick(lines, r_r.ctrl[`ATS_CTL_SRC_MSB:`ATS_CTL_SRC_LSB]);
		ref_lvl = pick(lines, r_r.ctrl[`ATS_CTL_REF_MSB:`ATS_CTL_REF_LSB]);
		start_edge = r_r.ctrl[`ATS_CTL_FALL] ? (r_r.strg_d & ~start_lvl)
			: (~r_r.strg_d & start_lvl);
		ref_edge = r_r.ctrl[`ATS_CTL_REF_FALL] ? (r_r.rtrg_d & ~ref_lvl)
			: (~r_r.rtrg_d & ref_lvl);
		ana_rise = r_r.s2[SW] & ~r_r.ana_d;
		escan_rise = r_r.s2[SW+1] & ~r_r.escan_d;
		r_nxt.s1 = {2'h0, ext_scan_clock, analog_compare_event,
			internal_trigger, backplane_trigger_line,
			programmable_function_line};
		r_nxt.s2 = r_r.s1;
		r_nxt.strg_d = start_lvl;
		r_nxt.rtrg_d = ref_lvl;
		r_nxt.ana_d = r_r.s2[SW];
		r_nxt.escan_d = r_r.s2[SW+1];
		r_nxt.rdata = 32'h0;
		r_nxt.scan = 1'b0;
		r_nxt.conv = 1'b0;
		r_nxt.pin_o = 1'b0;
		go = 1'b0;
		scan_pulse = 1'b0;

		// ****************************************
		// Register port
		// ****************************************
		// Status and count are read-only: their writes fall to the default
		if (reg_wr) begin
			unique case (reg_addr)
				`ATS_REG_CTRL:    r_nxt.ctrl = reg_wdata;
				`ATS_REG_PRE:     r_nxt.pre_cnt = reg_wdata[CW-1:0];
				`ATS_REG_POST:    r_nxt.post_cnt = reg_wdata[CW-1:0];
				`ATS_REG_SCANDIV: r_nxt.scan_div = reg_wdata[15:0];
				`ATS_REG_CONVDIV: r_nxt.conv_div = reg_wdata[15:0];
				`ATS_REG_DELAY:   r_nxt.delay = reg_wdata[15:0];
				`ATS_REG_NCHAN:   r_nxt.nchan = reg_wdata[3:0];
				`ATS_REG_MODE_LO: r_nxt.modes[15:0] = reg_wdata[15:0];
				`ATS_REG_MODE_HI: r_nxt.modes[31:16] = reg_wdata[15:0];
				default: ;
			endcase
		end
		if (reg_rd) begin
			unique case (reg_addr)
				`ATS_REG_CTRL:    r_nxt.rdata = r_r.ctrl;
				`ATS_REG_STATUS:  r_nxt.rdata = {28'h0,
					r_r.st == ATS_PRE, r_r.st == ATS_ARMED, r_r.done,
					r_r.st != ATS_IDLE};
				`ATS_REG_PRE:     r_nxt.rdata = 32'(r_r.pre_cnt);
				`ATS_REG_POST:    r_nxt.rdata = 32'(r_r.post_cnt);
				`ATS_REG_SCANDIV: r_nxt.rdata = {16'h0, r_r.scan_div};
				`ATS_REG_CONVDIV: r_nxt.rdata = {16'h0, r_r.conv_div};
				`ATS_REG_DELAY:   r_nxt.rdata = {16'h0, r_r.delay};
				`ATS_REG_NCHAN:   r_nxt.rdata = {28'h0, r_r.nchan};
				`ATS_REG_MODE_LO: r_nxt.rdata = {16'h0, r_r.modes[15:0]};
				`ATS_REG_MODE_HI: r_nxt.rdata = {16'h0, r_r.modes[31:16]};
				`ATS_REG_COUNT:   r_nxt.rdata = 32'(r_r.count);
				default:          r_nxt.rdata = 32'h0;
			endcase
		end
		// Input mode by default; output only when software asks
		r_nxt.pin_oe_n = ~r_nxt.ctrl[`ATS_CTL_PIN_OUT];

		// ****************************************
		// Scan clock source
		// ****************************************
		if (r_r.st inside {ATS_PRE, ATS_ARMED, ATS_POST, ATS_CONT}) begin
			if (r_r.ctrl[`ATS_CTL_EXT_SCAN]) begin
				// Synchroniser adds two cycles of lag to external edges
				scan_pulse = escan_rise;
			end else if (r_r.tick <= 16'h1) begin
				scan_pulse = 1'b1;
				r_nxt.tick = r_r.scan_div;
			end else begin
				r_nxt.tick = r_r.tick - 16'h1;
			end
		end
		r_nxt.scan = scan_pulse;

		// ****************************************
		// Sequencer
		// ****************************************
		unique case (r_r.st)
			// Start commands outside idle are ignored
			ATS_IDLE: begin
				if (reg_wr && reg_addr == `ATS_REG_CMD
						&& reg_wdata[`ATS_CMD_START]) begin
					r_nxt.done = 1'b0;
					unique case (r_r.ctrl[`ATS_CTL_KIND_MSB:`ATS_CTL_KIND_LSB])
						`ATS_KIND_DIGITAL, `ATS_KIND_ANALOG:
							r_nxt.st = ATS_WAIT_TRIG;
						default: go = 1'b1;
					endcase
				end
			end
			ATS_WAIT_TRIG: begin
				if (r_r.ctrl[`ATS_CTL_KIND_MSB:`ATS_CTL_KIND_LSB]
						== `ATS_KIND_ANALOG)
					go = ana_rise;
				else
					go = start_edge;
			end
			ATS_DELAY: begin
				if (r_r.tick <= 16'h1) begin
					r_nxt.tick = 16'h0;
					r_nxt.st = r_r.ctrl[`ATS_CTL_CONT] ? ATS_CONT
						: r_r.ctrl[`ATS_CTL_PRETRIG] ? ATS_PRE : ATS_POST;
				end else begin
					r_nxt.tick = r_r.tick - 16'h1;
				end
			end
			ATS_PRE: begin
				if (scan_pulse) begin
					if (r_r.count <= CW'(1)) begin
						r_nxt.count = r_r.post_cnt;
						r_nxt.st = ATS_ARMED;
					end else begin
						r_nxt.count = r_r.count - CW'(1);
					end
				end
			end
			ATS_ARMED: begin
				// Buffer keeps sampling while waiting for the reference
				if (ref_edge || !r_r.ctrl[`ATS_CTL_REF_EN])
					r_nxt.st = ATS_POST;
			end
			ATS_POST: begin
				if (scan_pulse) begin
					r_nxt.count = r_r.count - CW'(1);
					if (r_r.count <= CW'(1)) begin
						r_nxt.st = ATS_IDLE;
						r_nxt.done = 1'b1;
					end
				end
			end
			ATS_CONT: ;
		endcase
		if (go) begin
			r_nxt.st = ATS_DELAY;
			// External pacing skips the delay: its own edges time the samples
			r_nxt.tick = r_r.ctrl[`ATS_CTL_EXT_SCAN] ? 16'h1 : r_r.delay;
			r_nxt.count = r_r.ctrl[`ATS_CTL_PRETRIG] ? r_r.pre_cnt
				: r_r.post_cnt;
			// Pin shows the start trigger from any source
			r_nxt.pin_o = 1'b1;
		end
		if (reg_wr && reg_addr == `ATS_REG_CMD) begin
			if (reg_wdata[`ATS_CMD_STOP])
				r_nxt.st = ATS_IDLE;
			// Completion in the same cycle wins over the clear
			if (reg_wdata[`ATS_CMD_CLR_DONE] && !(r_nxt.done && !r_r.done))
				r_nxt.done = 1'b0;
		end
		// Running flag is a register so the pin has no decode glitches
		r_nxt.run = (r_nxt.st != ATS_IDLE);

		// ****************************************
		// Conversion clock within a sample
		// ****************************************
		// A new scan restarts the list: too slow a conversion clock cuts it
		if (scan_pulse && r_r.st != ATS_DELAY) begin
			r_nxt.conv_busy = 1'b1;
			r_nxt.conv_lead = 1'b1;
			r_nxt.chan = 4'h0;
			r_nxt.ctick = 16'h0;
		end else if (r_r.conv_busy) begin
			if (r_r.ctick > 16'h1) begin
				r_nxt.ctick = r_r.ctick - 16'h1;
			end else if (!r_r.conv_lead && r_r.chan >= r_r.nchan) begin
				// Last channel converted; wait for the next scan
				r_nxt.conv_busy = 1'b0;
			end else begin
				r_nxt.conv = 1'b1;
				r_nxt.conv_lead = 1'b0;
				r_nxt.ctick = r_r.conv_div;
				// Channel advances on every conversion but the first
				if (!r_r.conv_lead)
					r_nxt.chan = r_r.chan + 4'h1;
			end
		end

		// ****************************************
		// Input multiplexer
		// ****************************************
		pchan = r_nxt.chan;
		cm = mode_of(r_r.modes, pchan);
		pm = mode_of(r_r.modes, pchan ^ `ATS_DIFFERENTIAL_INPUT_MODE_OFFSET);
		r_nxt.mux.convert = r_nxt.conv;
		r_nxt.mux.chan = pchan;
		// Upper input of a differential pair cannot also be a channel
		r_nxt.mux.pos_sel_valid = (cm != ATS_IN_OFF)
			&& !(pchan[3] && pm == ATS_IN_DIFFERENTIAL_INPUT_MODE)
			&& !(cm == ATS_IN_DIFFERENTIAL_INPUT_MODE && pchan[3]);
		r_nxt.mux.neg_to_mux = (cm == ATS_IN_DIFFERENTIAL_INPUT_MODE) && !pchan[3];
		r_nxt.mux.neg_chan = 4'(pchan + `ATS_DIFFERENTIAL_INPUT_MODE_OFFSET);
		r_nxt.mux.neg_to_sense = (cm == ATS_IN_SENSED);
		r_nxt.mux.neg_to_ground = (cm == ATS_IN_GROUNDED);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r_r <= '0;
			// Dividers and delay leave reset at their working defaults
			r_r.scan_div <= `ATS_DIV_RST;
			r_r.conv_div <= `ATS_DIV_RST;
			r_r.delay <= `ATS_DELAY_RST;
			r_r.pin_oe_n <= 1'b1;
		end else begin
			r_r <= r_nxt;
		end
	end

	assign reg_rdata = r_r.rdata;
	assign start_trigger_pin_o = r_r.pin_o;
	assign start_trigger_pin_oe_n = r_r.pin_oe_n;
	assign scan_clock = r_r.scan;
	assign conversion_clock = r_r.conv;
	assign acq_running = r_r.run;
	assign mux_ctl = r_r.mux;

endmodule : ats_sequencer
`default_nettype wire

// ===== ats_cfg.svh
// Purpose: constants for the acquisition trigger sequencer
// Assumes: 10 MHz clk, plain register port with 8-bit word addresses
// Notes:   offsets are word addresses on the register port
`ifndef ATS_CFG_SVH
`define ATS_CFG_SVH

// ****************************************
// Register offsets
// ****************************************
`define ATS_REG_CTRL     8'h00
`define ATS_REG_CMD      8'h01
`define ATS_REG_STATUS   8'h02
`define ATS_REG_PRE      8'h03
`define ATS_REG_POST     8'h04
`define ATS_REG_SCANDIV  8'h05
`define ATS_REG_CONVDIV  8'h06
`define ATS_REG_DELAY    8'h07
`define ATS_REG_NCHAN    8'h08
`define ATS_REG_MODE_LO  8'h09
`define ATS_REG_MODE_HI  8'h0a
`define ATS_REG_COUNT    8'h0b

// ****************************************
// Control fields
// ****************************************
`define ATS_CTL_SRC_LSB   0
`define ATS_CTL_SRC_MSB   4
`define ATS_CTL_FALL      5
`define ATS_CTL_KIND_LSB  6
`define ATS_CTL_KIND_MSB  7
`define ATS_CTL_CONT      8
`define ATS_CTL_PRETRIG   9
`define ATS_CTL_PIN_OUT   10
`define ATS_CTL_REF_FALL  11
`define ATS_CTL_REF_LSB   12
`define ATS_CTL_REF_MSB   16
`define ATS_CTL_REF_EN    17
`define ATS_CTL_EXT_SCAN  18

// Trigger kinds
`define ATS_KIND_NONE     2'h0
`define ATS_KIND_DIGITAL  2'h1
`define ATS_KIND_ANALOG   2'h2
`define ATS_KIND_SOFT     2'h3

// Command bits
`define ATS_CMD_START     0
`define ATS_CMD_STOP      1
`define ATS_CMD_CLR_DONE  2

// Status bits
`define ATS_ST_RUN        0
`define ATS_ST_DONE       1
`define ATS_ST_ARMED      2
`define ATS_ST_PRE        3

// ****************************************
// Reset values and sizes
// ****************************************
`define ATS_DELAY_RST     16'h0002
`define ATS_DIV_RST       16'h0001
`define ATS_DIFFERENTIAL_INPUT_MODE_OFFSET   4'h8
`define ATS_NUM_PFI       10
`define ATS_NUM_BTL       7
`define ATS_NUM_INT       4
`define ATS_PULSE_NS      100
`define ATS_CLK_NS        100
`define ATS_PULSE_CYC     ((`ATS_PULSE_NS + `ATS_CLK_NS - 1) / `ATS_CLK_NS)

`endif

// ===== ats_pkg.sv
// Purpose: types for the acquisition trigger sequencer
// Assumes: ats_cfg.svh provides the constants
// Notes:   modes are two bits per multiplexer input
package ats_pkg;

	typedef enum logic [1:0] {
		ATS_IN_OFF,
		ATS_IN_DIFFERENTIAL_INPUT_MODE,
		ATS_IN_GROUNDED,
		ATS_IN_SENSED
	} ats_inmode_t;

	typedef enum logic [2:0] {
		ATS_IDLE,
		ATS_WAIT_TRIG,
		ATS_DELAY,
		ATS_PRE,
		ATS_ARMED,
		ATS_POST,
		ATS_CONT
	} ats_state_t;

	typedef struct packed {
		logic convert;
		logic [3:0] chan;
		logic pos_sel_valid;
		logic neg_to_sense;
		logic neg_to_ground;
		logic neg_to_mux;
		logic [3:0] neg_chan;
	} ats_mux_t;

endpackage : ats_pkg

// ===== ats_sequencer_assertions.sv
// Purpose: port checks of ats_sequencer
// Assumes: one clock, async low reset
// Notes:   bound to every instance
`timescale 1ns/1ps
`default_nettype none
module ats_seq_chk
	import ats_pkg::*;
(
	// Clock and reset
	input wire logic     clk,
	input wire logic     rst_n,
	// Watched outputs
	input wire logic     start_trigger_pin_o,
	input wire logic     start_trigger_pin_oe_n,
	input wire logic     scan_clock,
	input wire logic     acq_running,
	input wire ats_mux_t mux_ctl
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ****
	// Properties
	// ****
	chk_pin_single: assert property (
		start_trigger_pin_o |=> !start_trigger_pin_o)
		else $error("start pulse too long");
	chk_pin_runs: assert property (
		$rose(start_trigger_pin_o) |-> acq_running)
		else $error("start pulse while idle");
	chk_pin_input: assert property (
		$rose(rst_n) |-> start_trigger_pin_oe_n)
		else $error("start pin driven after reset");
	chk_first_gap: assert property (
		start_trigger_pin_o |-> !scan_clock ##1 !scan_clock)
		else $error("scan too soon after start");
	chk_idle_quiet: assert property (
		!$past(acq_running) |-> !scan_clock)
		else $error("scan while idle");
	chk_stop_quiet: assert property (
		$fell(acq_running) |=> !scan_clock [*2])
		else $error("scan after stop");
	chk_differential_input_mode_pair: assert property (
		mux_ctl.pos_sel_valid && mux_ctl.neg_to_mux |-> !mux_ctl.chan[3]
		&& mux_ctl.neg_chan == mux_ctl.chan + 4'h8)
		else $error("differential partner wrong");
	chk_one_leg: assert property (
		mux_ctl.pos_sel_valid |-> $onehot({mux_ctl.neg_to_sense,
		mux_ctl.neg_to_ground, mux_ctl.neg_to_mux}))
		else $error("negative leg not unique");
	cover property ($rose(start_trigger_pin_o));
	cover property (mux_ctl.neg_to_sense);
	cover property ($fell(acq_running));
endmodule : ats_seq_chk
bind ats_sequencer ats_seq_chk i_chk (.clk(clk), .rst_n(rst_n),
	.start_trigger_pin_o(start_trigger_pin_o),
	.start_trigger_pin_oe_n(start_trigger_pin_oe_n),
	.scan_clock(scan_clock), .acq_running(acq_running),
	.mux_ctl(mux_ctl));
`default_nettype wire

// ===== ats_trig_model.sv
// Purpose: trigger sources facing ats_sequencer
// Assumes: lines change only on bench request
// Notes:   external scan input moves only on bench request
`include "ats_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module ats_trig_model (
	// Trigger lines
	output var logic [`ATS_NUM_PFI-1:0] programmable_function_line,
	output var logic [`ATS_NUM_BTL-1:0] backplane_trigger_line,
	output var logic [`ATS_NUM_INT-1:0] internal_trigger,
	// Comparator and scan input
	output var logic                    analog_compare_event,
	output var logic                    ext_scan_clock
);
	logic [20:0] lvl = '0;
	logic        cmp = 1'b0;
	logic        esc_lvl = 1'b0;
	always_comb begin
		programmable_function_line = lvl[9:0];
		backplane_trigger_line = lvl[16:10];
		internal_trigger = lvl[20:17];
		analog_compare_event = cmp;
		ext_scan_clock = esc_lvl;
	end
	task automatic set_line(input int idx, input logic lv);
		lvl[idx] <= lv;
	endtask : set_line
	task automatic set_cmp(input logic lv);
		cmp <= lv;
	endtask : set_cmp
	task automatic set_scan(input logic lv);
		esc_lvl <= lv;
	endtask : set_scan
endmodule : ats_trig_model
`default_nettype wire

// ===== ats_sequencer_tb.sv
// Purpose: self-checking bench of ats_sequencer
// Assumes: 10 MHz clk, model drives triggers
// Notes:   scan and start pulses are counted
`include "ats_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module ats_sequencer_tb
	import ats_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  reg_addr = '0;
	logic [31:0] reg_wdata = '0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] reg_rdata, v, n, d, scans, pins, convs, t0, t1;
	logic [31:0] cyc = '0;
	logic [31:0] mode_r = '0;
	logic [15:0] seen;
	logic [9:0]  fl;
	logic [6:0]  bl;
	logic [3:0]  it;
	logic        ace, esc, pin, oe_n, scan, conv, run;
	logic        mon = 1'b0;
	logic        cprev = 1'b0;
	ats_mux_t    mux;
	int          s;
	int          bad_count = 0;
	int          compares = 0;
	ats_sequencer i_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .programmable_function_line(fl),
		.backplane_trigger_line(bl), .internal_trigger(it),
		.analog_compare_event(ace), .ext_scan_clock(esc),
		.start_trigger_pin_o(pin), .start_trigger_pin_oe_n(oe_n),
		.scan_clock(scan), .conversion_clock(conv),
		.acq_running(run), .mux_ctl(mux));
	ats_trig_model i_src (.programmable_function_line(fl),
		.backplane_trigger_line(bl), .internal_trigger(it),
		.analog_compare_event(ace), .ext_scan_clock(esc));
	// ****
	// Helpers
	// ****
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	function automatic logic [31:0] leg(input logic [3:0] c);
		case (mode_r[2*c +: 2])
			2'h1: return 32'h1;
			2'h2: return 32'h2;
			2'h3: return 32'h4;
			default: return 32'h0;
		endcase
	endfunction : leg
	task automatic conclude();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : conclude
	task automatic wr(input logic [7:0] a, input logic [31:0] dt);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= dt;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] dt);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		dt = reg_rdata;
	endtask : rd
	task automatic go(input logic [31:0] c);
		wr(`ATS_REG_CTRL, c);
		scans = '0;
		pins = '0;
		convs = '0;
		wr(`ATS_REG_CMD, 32'h1);
	endtask : go
	task automatic fin(input logic [31:0] want);
		for (int i = 0; i < 900 && run !== 1'b0; i++)
			@(negedge clk);
		// Let the monitor count the scan that ends the run
		repeat (2) @(negedge clk);
		chk("idle", 32'h0, 32'(run));
		chk("scans", want, scans);
	endtask : fin
	// ****
	// Clock, monitor, timeout
	// ****
	initial forever #50 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (scan === 1'b1 && scans == 0) t1 = cyc;
		if (scan === 1'b1) scans++;
		if (pin === 1'b1) t0 = cyc;
		if (pin === 1'b1) pins++;
		if (conv === 1'b1) convs++;
		if (mon && conv === 1'b1)
			chk("conv gap", 32'h0, 32'(cprev));
		cprev = (conv === 1'b1);
		if (mon && mux.convert === 1'b1 && mux.pos_sel_valid === 1'b1) begin
			seen[mux.chan] = 1'b1;
			chk("leg", leg(mux.chan), 32'({mux.neg_to_sense,
				mux.neg_to_ground, mux.neg_to_mux}));
		end
		if (cyc == 60000) begin
			bad_count++;
			conclude();
		end
	end
	// ****
	// Tests
	// ****
	initial begin
		void'($urandom(82963));
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		chk("oe_n", 32'h1, 32'(oe_n));
		rd(`ATS_REG_DELAY, v);
		chk("delay", 32'(`ATS_DELAY_RST), v);
		rd(8'h3f, v);
		chk("unmapped", 32'h0, v);
		$display("reset test done");
		for (int k = 0; k < 2; k++) begin
			n = $urandom_range(6, 1);
			d = k ? $urandom_range(5, 3) : 2;
			wr(`ATS_REG_POST, n);
			wr(`ATS_REG_DELAY, d);
			go(k ? 32'h4c0 : 32'h0);
			@(negedge clk);
			chk("oe_n", k ? 0 : 1, 32'(oe_n));
			fin(n);
			chk("pulses", 32'h1, pins);
			chk("first scan", d + 1, t1 - t0);
			rd(`ATS_REG_STATUS, v);
			chk("done", 32'h1, 32'(v[`ATS_ST_DONE]));
			wr(`ATS_REG_CMD, 32'h4);
			rd(`ATS_REG_STATUS, v);
			chk("done clear", 32'h0, 32'(v[`ATS_ST_DONE]));
		end
		$display("posttrigger test done");
		for (int k = 0; k < 4; k++) begin
			s = $urandom_range(20, 0);
			n = $urandom_range(4, 1);
			i_src.set_line(s, !k[0]);
			wr(`ATS_REG_POST, n);
			go(32'h40 | 32'(s) | 32'(k[0]) << 5);
			i_src.set_line(s, k[0]);
			repeat (8) @(posedge clk);
			chk("wrong edge", 32'h0, pins);
			i_src.set_line(s, !k[0]);
			fin(n);
		end
		go(32'h80);
		repeat (8) @(posedge clk);
		chk("no compare", 32'h0, pins);
		i_src.set_cmp(1'b1);
		fin(n);
		i_src.set_cmp(1'b0);
		$display("trigger test done");
		n = $urandom_range(3, 2);
		d = $urandom_range(3, 2);
		wr(`ATS_REG_SCANDIV, 32'h10);
		wr(`ATS_REG_PRE, d);
		wr(`ATS_REG_POST, n);
		s = $urandom_range(1, 0);
		i_src.set_line(10, s[0]);
		go(32'h2a200 | 32'(s) << 11);
		i_src.set_line(10, !s[0]);
		repeat (3) @(posedge clk);
		i_src.set_line(10, s[0]);
		repeat (16 * d + 40) @(posedge clk);
		chk("early ref", 32'h1, 32'(run));
		rd(`ATS_REG_STATUS, v);
		chk("armed", 32'h1, 32'(v[`ATS_ST_ARMED]));
		rd(`ATS_REG_COUNT, v);
		chk("reload", n, v);
		while (scan !== 1'b1)
			@(negedge clk);
		@(posedge clk);
		i_src.set_line(10, !s[0]);
		@(negedge clk);
		t0 = scans;
		fin(t0 + n);
		i_src.set_line(10, 1'b0);
		$display("pretrigger test done");
		mode_r = 32'h0002_0039;
		wr(`ATS_REG_MODE_LO, 32'h39);
		wr(`ATS_REG_MODE_HI, 32'h2);
		wr(`ATS_REG_NCHAN, 32'h8);
		wr(`ATS_REG_SCANDIV, 32'h20);
		wr(`ATS_REG_CONVDIV, 32'h2);
		seen = '0;
		mon = 1'b1;
		go(32'h100);
		repeat (300) @(posedge clk);
		chk("continuous", 32'h1, 32'(run));
		chk("pacing", 32'h1, 32'(convs >= scans && scans > n));
		wr(`ATS_REG_CMD, 32'h2);
		mon = 1'b0;
		repeat (2) @(negedge clk);
		chk("stopped", 32'h0, 32'(run));
		chk("inputs used", 32'h7, 32'(seen));
		$display("continuous test done");
		n = $urandom_range(5, 2);
		wr(`ATS_REG_POST, n);
		go(32'h40000);
		repeat (20) @(posedge clk);
		chk("no ext scan", 32'h0, scans);
		for (int k = 0; k < 8 && run === 1'b1; k++) begin
			i_src.set_scan(1'b1);
			repeat (4) @(posedge clk);
			i_src.set_scan(1'b0);
			repeat (4) @(posedge clk);
		end
		fin(n);
		$display("external scan test done");
		conclude();
	end
endmodule : ats_sequencer_tb
`default_nettype wire
